// ### rtl/ptp_timebase_defines.vh
// Constants for the timebase supervision and announce field logic.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef PTP_TIMEBASE_DEFINES_VH
`define PTP_TIMEBASE_DEFINES_VH

// Clock rate and timing
`define CLK_FREQ_HZ 125000000
`define PPS_LOSS_NS 1500000000
`define PPS_LOSS_CYCLES (`PPS_LOSS_NS / 8)
`define LOCK_HOLD_SEC 60
`define NS_PER_CYCLE 8

// Traceability configurations
`define CFG_ATOMIC 2'h0
`define CFG_COMMON 2'h1
`define CFG_FREQ 2'h2

// Reference states
`define ST_FREERUN 2'h0
`define ST_LOCKED 2'h1
`define ST_HOLDOVER 2'h2

// Announce defaults
`define CLASS_ATOMIC_DFLT 8'h06
`define CLASS_COMMON_DFLT 8'h0d
`define SRC_INTERNAL_OSC 8'ha0

// Seconds rollover phase step limit per cycle, in ns
`define NS_PER_SEC 30'h3b9aca00
`define PHASE_STEP_MAX 30'h00000010

`endif

// ### rtl/pps_activity_monitor.v
// Pulse-per-second activity monitor: synchroniser, edge detect, watchdog.
// Assumes core_clk at 125 MHz and a free-running reference pin.
`timescale 1ns/1ps
`include "ptp_timebase_defines.vh"

module pps_activity_monitor #(
	parameter LOSS_CYCLES = `PPS_LOSS_CYCLES
) (
	input wire core_clk, // System clock
	input wire srst, // Synchronous reset, active high
	input wire pps_pin, // Raw reference pulse pin
	output reg pps_rise, // One-cycle pulse on rising edge
	output reg pps_good // Reference seen within the window
);

	reg sync1_reg;
	reg sync2_reg;
	reg last_reg;
	reg [31:0] wd_reg;

	// ************************************************
	// Two-stage synchroniser and watchdog
	// ************************************************
	always @(posedge core_clk) begin
		if (srst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			last_reg <= 1'b0;
			wd_reg <= 32'h00000000;
			pps_rise <= 1'b0;
			pps_good <= 1'b0;
		end else begin
			sync1_reg <= pps_pin;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
			pps_rise <= sync2_reg & ~last_reg;
			// Watchdog restarts on each edge; expiry marks loss
			if (sync2_reg & ~last_reg) begin
				wd_reg <= 32'h00000000;
				pps_good <= 1'b1;
			end else if (wd_reg >= LOSS_CYCLES) begin
				pps_good <= 1'b0;
			end else begin
				wd_reg <= wd_reg + 32'h00000001;
			end
		end
	end

endmodule

// ### rtl/ptp_timebase_traceability.v
// Timebase supervision and announce traceability fields of a grandmaster.
// Assumes host configuration ports are static or change between frames.
// Notes on behaviour
// - Watch the pulse reference; on loss it no longer steers timebase rate.
// - On loss, go to holdover if any lock since the last free-run lasted long enough, else free-run.
// - Never switch reference by itself when the pulse input fails.
// - Common-phase: align timebase to supplied epoch, treated as arbitrary.
// - Non-traceable: event timestamps carry arbitrary-timescale values.
// - Common-phase and frequency: timescale, leap flags false; freq true.
// - Non-traceable configurations mark UTC offset invalid.
// - Common-phase: configured time source, clock class default 13.
// - Frequency-only: internal oscillator source, configured class.
// - Frequency-only: timebase free with own epoch, rate from reference; here it runs unsteered at 8 ns per cycle.
// - Configurable static asymmetry compensation.
// - Use correction-field asymmetry data to reduce offset error.
// - Atomic-traceable: all trace flags true, UTC valid, class default 6.
// - While reference good, except in frequency-only mode, steer seconds rollover onto its rising edge.
`timescale 1ns/1ps
`include "ptp_timebase_defines.vh"

module ptp_timebase_traceability #(
	parameter LOSS_CYCLES = `PPS_LOSS_CYCLES,
	parameter LOCK_SECONDS = `LOCK_HOLD_SEC
) (
	input wire core_clk, // System clock
	input wire srst, // Synchronous reset, active high
	input wire pps_pin, // Pulse-per-second reference pin
	input wire [1:0] trace_cfg, // Traceability configuration
	input wire class_override_en, // Use configured clock class
	input wire [7:0] class_cfg, // Configured clock class
	input wire [7:0] time_source_cfg, // Configured time source
	input wire [15:0] utc_offset_cfg, // Configured UTC offset
	input wire leap59_cfg, // Leap flag inputs for traceable mode
	input wire leap61_cfg, // Leap flag inputs
	input wire epoch_load, // Load supplied epoch seconds, pulse
	input wire [47:0] epoch_sec, // Supplied epoch seconds
	input wire signed [31:0] asym_static_ns, // Static asymmetry, ns
	input wire signed [31:0] corr_asym_ns, // Correction-field asymmetry
	input wire corr_valid, // Correction data valid
	output reg [47:0] tb_sec, // Timebase seconds
	output reg [29:0] tb_ns, // Timebase nanoseconds
	output reg tb_arbitrary, // Timestamps on arbitrary timescale
	output reg [1:0] ref_state, // Free-run, locked, holdover
	output reg pps_ok, // Reference good
	output reg ann_ptp_timescale, // Announce timescale flag
	output reg ann_leap59, // Announce leap flag
	output reg ann_leap61, // Announce leap flag
	output reg ann_time_traceable, // Announce time traceable flag
	output reg ann_freq_traceable, // Announce frequency traceable flag
	output reg ann_utc_valid, // Announce UTC offset valid
	output reg [15:0] ann_utc_offset, // Announce UTC offset
	output reg [7:0] ann_time_source, // Announce time source
	output reg [7:0] ann_clock_class, // Announce clock class
	output reg signed [31:0] asym_comp_ns // Total asymmetry compensation
);

	wire pps_rise;
	wire pps_good;
	reg [1:0] state_next;
	reg [7:0] lock_cnt_reg;
	reg holdover_ok_reg;
	reg signed [30:0] phase_err_reg;
	reg [29:0] step_reg;
	reg [29:0] ns_next;
	reg roll;

	// Per-cycle increment held at the timebase width
	localparam [29:0] CYCLE_NS = `NS_PER_CYCLE;

	// ************************************************
	// Reference activity monitor
	// ************************************************
	pps_activity_monitor #(
		.LOSS_CYCLES(LOSS_CYCLES)
	) u_mon (
		.core_clk(core_clk),
		.srst(srst),
		.pps_pin(pps_pin),
		.pps_rise(pps_rise),
		.pps_good(pps_good)
	);

	// Steering only while locked and not in frequency-only mode
	wire steer = (ref_state == `ST_LOCKED) && (trace_cfg != `CFG_FREQ);

	// ************************************************
	// Reference state machine
	// ************************************************
	always @* begin
		state_next = ref_state;
		case (ref_state)
			`ST_FREERUN: begin
				if (pps_good)
					state_next = `ST_LOCKED;
			end
			`ST_LOCKED: begin
				// No switch to another input is attempted here
				if (!pps_good)
					state_next = holdover_ok_reg ? `ST_HOLDOVER
						: `ST_FREERUN;
			end
			`ST_HOLDOVER: begin
				if (pps_good)
					state_next = `ST_LOCKED; // Host reselected source
			end
			default: state_next = `ST_FREERUN;
		endcase
	end

	// Lock-time accounting for holdover data
	always @(posedge core_clk) begin
		if (srst) begin
			ref_state <= `ST_FREERUN;
			lock_cnt_reg <= 8'h00;
			holdover_ok_reg <= 1'b0;
			pps_ok <= 1'b0;
		end else begin
			ref_state <= state_next;
			pps_ok <= pps_good;
			if (ref_state != `ST_LOCKED) begin
				lock_cnt_reg <= 8'h00;
				if (ref_state == `ST_FREERUN)
					holdover_ok_reg <= 1'b0;
			end else if (pps_rise) begin
				if ({24'h000000, lock_cnt_reg} >= LOCK_SECONDS - 1)
					holdover_ok_reg <= 1'b1;
				else
					lock_cnt_reg <= lock_cnt_reg + 8'h01;
			end
		end
	end

	// ************************************************
	// Timebase counter and rollover steering
	// ************************************************
	always @* begin
		ns_next = tb_ns + CYCLE_NS + step_reg;
		roll = (ns_next >= `NS_PER_SEC);
		if (roll)
			ns_next = ns_next - `NS_PER_SEC;
	end

	always @(posedge core_clk) begin
		if (srst) begin
			tb_sec <= 48'h000000000000;
			tb_ns <= 30'h00000000;
			step_reg <= 30'h00000000;
			phase_err_reg <= 31'h00000000;
			tb_arbitrary <= 1'b1;
		end else begin
			// Arbitrary timescale outside atomic mode
			tb_arbitrary <= (trace_cfg != `CFG_ATOMIC);
			if (epoch_load && trace_cfg != `CFG_FREQ) begin
				tb_sec <= epoch_sec; // Align to supplied epoch
			end else if (roll) begin
				tb_sec <= tb_sec + 48'h000000000001; // Own epoch
			end
			tb_ns <= ns_next;
			// Measure rollover error on each reference edge while steering
			if (steer && pps_rise) begin
				if (tb_ns >= (`NS_PER_SEC >> 1))
					phase_err_reg <= $signed({1'b0, `NS_PER_SEC - tb_ns});
				else
					phase_err_reg <= -$signed({1'b0, tb_ns});
			end
			// Bounded slew toward the edge; zeroed when unsteered
			// Small remainders are slewed too, so no residual error stays
			if (!steer || pps_rise)
				step_reg <= 30'h00000000;
			else if (phase_err_reg > $signed({1'b0, `PHASE_STEP_MAX}))
				step_reg <= `PHASE_STEP_MAX;
			else if (phase_err_reg > 0)
				step_reg <= phase_err_reg[29:0];
			else
				step_reg <= 30'h00000000;
			if (steer && phase_err_reg > 0 && pps_rise == 1'b0) begin
				if (phase_err_reg > $signed({1'b0, `PHASE_STEP_MAX}))
					phase_err_reg <= phase_err_reg
						- $signed({1'b0, `PHASE_STEP_MAX});
				else
					phase_err_reg <= 31'h00000000;
			end else if (steer && phase_err_reg < 0 && pps_rise == 1'b0) begin
				// Ahead of edge: hold one cycle, skipping an increment
				phase_err_reg <= phase_err_reg + 31'sd8;
				tb_ns <= tb_ns;
			end else if (!steer) begin
				phase_err_reg <= 31'h00000000;
			end
		end
	end

	// ************************************************
	// Announce field set and asymmetry compensation
	// ************************************************
	always @(posedge core_clk) begin
		if (srst) begin
			ann_ptp_timescale <= 1'b0;
			ann_leap59 <= 1'b0;
			ann_leap61 <= 1'b0;
			ann_time_traceable <= 1'b0;
			ann_freq_traceable <= 1'b1;
			ann_utc_valid <= 1'b0;
			ann_utc_offset <= 16'h0000;
			ann_time_source <= `SRC_INTERNAL_OSC;
			ann_clock_class <= `CLASS_COMMON_DFLT;
			asym_comp_ns <= 32'h00000000;
		end else begin
			ann_utc_offset <= utc_offset_cfg;
			ann_freq_traceable <= 1'b1;
			case (trace_cfg)
				`CFG_ATOMIC: begin
					ann_ptp_timescale <= 1'b1;
					ann_leap59 <= leap59_cfg;
					ann_leap61 <= leap61_cfg;
					ann_time_traceable <= 1'b1;
					ann_utc_valid <= 1'b1;
					ann_time_source <= time_source_cfg;
					ann_clock_class <= class_override_en ? class_cfg
						: `CLASS_ATOMIC_DFLT;
				end
				`CFG_COMMON: begin
					ann_ptp_timescale <= 1'b0;
					ann_leap59 <= 1'b0;
					ann_leap61 <= 1'b0;
					ann_time_traceable <= 1'b0;
					ann_utc_valid <= 1'b0;
					ann_time_source <= time_source_cfg;
					ann_clock_class <= class_override_en ? class_cfg
						: `CLASS_COMMON_DFLT;
				end
				default: begin
					ann_ptp_timescale <= 1'b0;
					ann_leap59 <= 1'b0;
					ann_leap61 <= 1'b0;
					ann_time_traceable <= 1'b0;
					ann_utc_valid <= 1'b0;
					ann_time_source <= `SRC_INTERNAL_OSC;
					ann_clock_class <= class_cfg;
				end
			endcase
			// Static term plus correction-field term
			asym_comp_ns <= asym_static_ns
				+ (corr_valid ? corr_asym_ns : 32'sh00000000);
		end
	end

endmodule

// ### verification/pps_source.sv
// Reference pulse source standing in for the timing input.
// Assumes core_clk; the pin idles low while stopped.
`timescale 1ns/1ps
module pps_source #(
	parameter PERIOD = 40
) (
	input wire core_clk, // Clock
	input wire run, // Source present
	output reg pps_pin // Reference pulse
);
	localparam [7:0] LAST = PERIOD - 1;
	reg [7:0] cnt_reg;
	// Four-cycle pulse at each period start
	always @(posedge core_clk) begin
		cnt_reg <= (!run || cnt_reg == LAST) ? 8'h00 : cnt_reg + 8'h01;
		pps_pin <= run && cnt_reg < 8'h04;
	end
endmodule

// ### verification/ptp_timebase_sva.sv
// Checker for announce fields, reference state and asymmetry.
// Assumes a bind to ptp_timebase_traceability; one clock domain.
`timescale 1ns/1ps
module ptp_timebase_sva (
	input wire core_clk, // Clock
	input wire srst, // Reset, active high
	input wire [1:0] trace_cfg, // Configuration
	input wire class_override_en, // Class override
	input wire corr_valid, // Correction data valid
	input wire pps_ok, // Reference good
	input wire [7:0] class_cfg, // Configured class
	input wire [7:0] time_source_cfg, // Configured source
	input wire signed [31:0] asym_static_ns, // Static asymmetry
	input wire signed [31:0] corr_asym_ns, // Correction asymmetry
	input wire tb_arbitrary, // Arbitrary timescale
	input wire ann_ptp_timescale, // Timescale flag
	input wire ann_leap59, // Leap flag
	input wire ann_leap61, // Leap flag
	input wire ann_time_traceable, // Time traceable flag
	input wire ann_freq_traceable, // Frequency traceable flag
	input wire ann_utc_valid, // UTC offset valid
	input wire [1:0] ref_state, // Reference state
	input wire [7:0] ann_time_source, // Time source
	input wire [7:0] ann_clock_class, // Clock class
	input wire signed [31:0] asym_comp_ns // Compensation
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// Flag set of the arbitrary timescale
	wire arb = !ann_ptp_timescale && !ann_leap59 && !ann_leap61 &&
		!ann_time_traceable && ann_freq_traceable && !ann_utc_valid;
	property p_freq;
		trace_cfg[1] |=> arb && ann_time_source == 8'ha0 &&
			ann_clock_class == $past(class_cfg);
	endproperty
	a_freq: assert property (p_freq)
		else $error("frequency announce set wrong");
	property p_common;
		trace_cfg == 2'h1 |=> arb &&
			ann_time_source == $past(time_source_cfg);
	endproperty
	a_common: assert property (p_common)
		else $error("common announce set wrong");
	property p_common_class;
		trace_cfg == 2'h1 |=> ann_clock_class ==
			($past(class_override_en) ? $past(class_cfg) : 8'h0d);
	endproperty
	a_common_class: assert property (p_common_class)
		else $error("common clock class wrong");
	property p_atomic;
		trace_cfg == 2'h0 |=> ann_ptp_timescale && ann_time_traceable &&
			ann_freq_traceable && ann_utc_valid;
	endproperty
	a_atomic: assert property (p_atomic)
		else $error("atomic announce set wrong");
	property p_atomic_class;
		trace_cfg == 2'h0 && !class_override_en |=> ann_clock_class == 8'h06;
	endproperty
	a_atomic_class: assert property (p_atomic_class)
		else $error("atomic clock class wrong");
	property p_arb;
		1'b1 |=> tb_arbitrary == ($past(trace_cfg) != 2'h0);
	endproperty
	a_arb: assert property (p_arb)
		else $error("timescale marking wrong");
	property p_asym;
		1'b1 |=> asym_comp_ns == $past(asym_static_ns) +
			($past(corr_valid) ? $past(corr_asym_ns) : 32'sh0);
	endproperty
	a_asym: assert property (p_asym)
		else $error("asymmetry sum wrong");
	property p_lost;
		!pps_ok && !$past(pps_ok) |-> ref_state != 2'h1;
	endproperty
	a_lost: assert property (p_lost)
		else $error("locked without reference");
	property p_fall;
		$fell(pps_ok) |-> ##[0:2] ref_state != 2'h1;
	endproperty
	a_fall: assert property (p_fall)
		else $error("lock kept after loss");
	property p_lock;
		$rose(pps_ok) |=> ref_state == 2'h1;
	endproperty
	a_lock: assert property (p_lock)
		else $error("no lock on good reference");
	c_hold: cover property (ref_state == 2'h2);
	c_free: cover property ($fell(pps_ok) ##[1:3] ref_state == 2'h0);
	c_corr: cover property (trace_cfg == 2'h2 && corr_valid);
endmodule

// ### verification/ptp_timebase_traceability_test.sv
// Self-checking bench of the timebase traceability block.
// Assumes the pulse source model and the bound checker.
`timescale 1ns/1ps
`define CHK(nm, ex, sv) begin num_checks = num_checks + 1; \
	if ((sv) !== (ex)) begin err_count = err_count + 1; \
	$display("BAD %s exp %0h got %0h", nm, ex, sv); end end
module ptp_timebase_traceability_test;
	reg core_clk, srst, run, ovr, ld, l59, l61, cv;
	reg [29:0] ns0;
	wire [29:0] ns;
	reg [1:0] cfg;
	reg [7:0] cls, src;
	reg [47:0] ep;
	reg signed [31:0] sa, ca, ex;
	integer err_count, num_checks, cycles, c, o;
	wire pps_pin, arb, ok, ts, f59, f61, tt, ft, uv;
	wire [47:0] sec;
	wire [1:0] st;
	wire [15:0] uo;
	wire [7:0] asrc, acls;
	wire signed [31:0] comp;
	pps_source #(.PERIOD(40)) src_m (.core_clk(core_clk), .run(run),
		.pps_pin(pps_pin));
	ptp_timebase_traceability #(.LOSS_CYCLES(50), .LOCK_SECONDS(3)) dut (
		.core_clk(core_clk), .srst(srst), .pps_pin(pps_pin),
		.trace_cfg(cfg), .class_override_en(ovr), .class_cfg(cls),
		.time_source_cfg(src), .utc_offset_cfg(16'h0025),
		.leap59_cfg(l59), .leap61_cfg(l61), .epoch_load(ld),
		.epoch_sec(ep), .asym_static_ns(sa), .corr_asym_ns(ca),
		.corr_valid(cv), .tb_sec(sec), .tb_ns(ns), .tb_arbitrary(arb),
		.ref_state(st), .pps_ok(ok), .ann_ptp_timescale(ts),
		.ann_leap59(f59), .ann_leap61(f61), .ann_time_traceable(tt),
		.ann_freq_traceable(ft), .ann_utc_valid(uv), .ann_utc_offset(uo),
		.ann_time_source(asrc), .ann_clock_class(acls),
		.asym_comp_ns(comp));
	// ****************************************
	// Scenarios
	// ****************************************
	task stop_test;
		begin
			$display("checks %0d errors %0d", num_checks, err_count);
			if (err_count == 0 && num_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// Every configuration with and without class override
	task t_cfg;
		for (c = 0; c < 4; c = c + 1) begin
			for (o = 0; o < 2; o = o + 1) begin
				@(posedge core_clk);
				cfg <= c[1:0];
				ovr <= o[0];
				repeat (2) @(posedge core_clk);
				#1;
				`CHK("timescale", c == 0, ts)
				`CHK("leap59", c == 0, f59)
				`CHK("leap61", c == 0, f61)
				`CHK("time_trace", c == 0, tt)
				`CHK("freq_trace", 1'b1, ft)
				`CHK("utc_valid", c == 0, uv)
				`CHK("utc_offset", 16'h0025, uo)
				`CHK("source", c > 1 ? 8'ha0 : 8'h20, asrc)
				`CHK("class", (o || c > 1) ? 8'h2a :
					(c == 0 ? 8'h06 : 8'h0d), acls)
				`CHK("arbitrary", c != 0, arb)
			end
		end
	endtask
	// Static and correction asymmetry summed
	task t_asym;
		for (o = 0; o < 2; o = o + 1) begin
			@(posedge core_clk);
			cv <= o[0];
			repeat (2) @(posedge core_clk);
			#1;
			ex = o ? -32'sd93 : -32'sd100;
			`CHK("asym", ex, comp)
		end
	endtask
	// Epoch taken in common phase, ignored in frequency mode
	task t_epoch(input [1:0] mode, input [47:0] exp_sec);
		begin
			@(posedge core_clk);
			cfg <= mode;
			repeat (2) @(posedge core_clk);
			ld <= 1'b1;
			ep <= ep + 48'h1111;
			@(posedge core_clk);
			ld <= 1'b0;
			#1;
			`CHK("epoch", exp_sec, sec)
		end
	endtask
	// Timebase advance over 16 cycles against the expected figure
	task t_rate(input [29:0] exp_adv);
		begin
			ns0 = ns;
			repeat (16) @(posedge core_clk);
			#1;
			`CHK("advance", exp_adv, ns - ns0)
		end
	endtask
	// Lock, steered or not by mode, then loss to free-run or holdover
	task t_loss(input [1:0] mode, input integer n, input [1:0] exp_st);
		begin
			@(posedge core_clk);
			cfg <= mode;
			run <= 1'b1;
			repeat (n * 40 + 10) @(posedge core_clk);
			#1;
			`CHK("locked", 2'h1, st)
			// Rollover ahead of the edge: retarded unless frequency only
			t_rate(mode == 2'h2 ? 30'h80 : 30'h0);
			@(posedge core_clk);
			run <= 1'b0;
			repeat (110) @(posedge core_clk);
			#1;
			`CHK("pps_ok", 1'b0, ok)
			`CHK("state", exp_st, st)
			// Lost reference no longer steers the rate
			t_rate(30'h80);
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_count = err_count + 1;
			stop_test;
		end
	end
	initial begin
		{srst, run, ovr, ld, cv, cfg} = 7'h40;
		{l59, l61, cls, src, ep} = {1'b1, 1'b1, 8'h2a, 8'h20, 48'h12345678};
		{sa, ca} = {-32'sd100, 32'sd7};
		{err_count, num_checks, cycles} = 96'h0;
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		`CHK("rst_class", 8'h0d, acls)
		`CHK("rst_src", 8'ha0, asrc)
		`CHK("rst_state", 2'h0, st)
		`CHK("rst_arb", 1'b1, arb)
		t_cfg;
		t_asym;
		t_epoch(2'h1, 48'h12346789);
		t_epoch(2'h2, 48'h12346789);
		t_loss(2'h0, 1, 2'h0);
		t_loss(2'h2, 6, 2'h2);
		// Host selects a working reference again
		t_loss(2'h1, 1, 2'h2);
		stop_test;
	end
endmodule
bind ptp_timebase_traceability ptp_timebase_sva u_sva (
	.core_clk(core_clk), .srst(srst), .trace_cfg(trace_cfg),
	.class_override_en(class_override_en), .corr_valid(corr_valid),
	.pps_ok(pps_ok), .class_cfg(class_cfg),
	.time_source_cfg(time_source_cfg), .asym_static_ns(asym_static_ns),
	.corr_asym_ns(corr_asym_ns), .tb_arbitrary(tb_arbitrary),
	.ann_ptp_timescale(ann_ptp_timescale), .ann_leap59(ann_leap59),
	.ann_leap61(ann_leap61), .ann_time_traceable(ann_time_traceable),
	.ann_freq_traceable(ann_freq_traceable), .ann_utc_valid(ann_utc_valid),
	.ref_state(ref_state), .ann_time_source(ann_time_source),
	.ann_clock_class(ann_clock_class), .asym_comp_ns(asym_comp_ns));
